//--- common/io_decode_pkg.sv
package io_decode_pkg;

   // ****************************************************************
   // Configuration offsets and fields
   // ****************************************************************
   localparam logic [7:0] OFF_IO_BASE_LOW = 8'h1c;
   localparam logic [7:0] OFF_IO_LIMIT_LOW = 8'h1d;
   localparam logic [7:0] OFF_IO_BASE_HIGH = 8'h30;
   localparam logic [7:0] OFF_IO_LIMIT_HIGH = 8'h32;
   localparam logic [3:0] IO_LOW_NIBBLE = 4'h1;
   localparam logic [11:0] BASE_FILL = 12'h000;
   localparam logic [11:0] LIMIT_FILL = 12'hfff;
   localparam logic [3:0] RST_BASE_NIB = 4'h0;
   localparam logic [3:0] RST_LIMIT_NIB = 4'h0;
   localparam logic [15:0] RST_HIGH = 16'h0000;
   localparam logic [15:0] ISA_HIGH_ZERO = 16'h0000;
   localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [1:0] size16;
      logic [15:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic [3:0] base_nib;
      logic [3:0] limit_nib;
      logic [15:0] base_high;
      logic [15:0] limit_high;
      logic [15:0] rdata;
      logic rvalid;
   } state_t;

endpackage

//--- verilog/io_address_decoder.sv
`timescale 1ns/1ps

// Behaviour
// - Window hits go down, outside misses go up.
// - Addresses pass untranslated; no decode gaps.
// - Clear I/O enable ignores primary I/O.
// - Clear master enable ignores secondary transactions.
// - Inside base..limit down, outside goes up.
// - Base above limit: nothing down, all up.
// - Window 4 KB aligned, up to 4 GB.
// - Base low byte: bits 15:12, nibble 1h.
// - Base high register gives address bits 31:16.
// - Reset clears whole 32-bit base.
// - Limit low byte: bits 15:12, fill FFFh.
// - Limit high register gives address bits 31:16.
// - Reset limit is 0000_0FFFh.
// - ISA bit acts only inside window below 64 KB.
// - ISA: only low 256 of each 1 KB forwarded.
// - Above 64 KB decode from window alone.
// - ISA upper 768 bytes forwarded up if mastering.
// - Otherwise up only when outside window.
module io_address_decoder (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Configuration access
   input wire io_decode_pkg::cfg_req_t cfg_i,
   output logic [15:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Command and bridge control bits
   input wire logic io_enable_i,
   input wire logic master_enable_i,
   input wire logic isa_enable_i,
   // Primary bus I/O address phase
   input wire logic pri_io_valid_i,
   input wire logic [31:0] pri_io_addr_i,
   output logic pri_fwd_down_o,
   // Secondary bus address phase
   input wire logic sec_valid_i,
   input wire logic sec_is_io_i,
   input wire logic [31:0] sec_addr_i,
   output logic sec_fwd_up_o,
   // Effective window
   output logic [31:0] io_base_o,
   output logic [31:0] io_limit_o
);
   import io_decode_pkg::*;

   state_t st;
   state_t next_st;
   logic [31:0] base;
   logic [31:0] limit;
   logic pri_in;
   logic sec_in;
   logic pri_isa_hole;
   logic sec_isa_hole;

   // ****************************************************************
   // Window and decode
   // ****************************************************************
   // Low bits are implied so the window is always 4 KB aligned.
   assign base = {st.base_high, st.base_nib, BASE_FILL};
   assign limit = {st.limit_high, st.limit_nib, LIMIT_FILL};

   // An inverted window means the two compares can never both pass.
   assign pri_in = (pri_io_addr_i >= base) && (pri_io_addr_i <= limit);
   assign sec_in = (sec_addr_i >= base) && (sec_addr_i <= limit);

   // The hole is decoded below 64 KB only; the window check is applied at the claim.
   assign pri_isa_hole = isa_enable_i
      && (pri_io_addr_i[31:16] == ISA_HIGH_ZERO)
      && (pri_io_addr_i[9:8] != ISA_LOW_QUARTER);
   assign sec_isa_hole = isa_enable_i
      && (sec_addr_i[31:16] == ISA_HIGH_ZERO)
      && (sec_addr_i[9:8] != ISA_LOW_QUARTER);

   // Downstream claim needs the I/O enable and a window hit.
   assign pri_fwd_down_o = pri_io_valid_i && io_enable_i
      && pri_in && !pri_isa_hole;

   // Upstream is the exact complement of the downstream claim, so the
   // flat address space has no gaps. Memory windows live elsewhere,
   // so non-I/O cycles are only gated by the master enable here.
   assign sec_fwd_up_o = sec_valid_i && master_enable_i
      && (!sec_is_io_i || !sec_in || sec_isa_hole);

   assign io_base_o = base;
   assign io_limit_o = limit;
   assign cfg_rdata_o = st.rdata;
   assign cfg_rvalid_o = st.rvalid;

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_comb begin
      next_st = st;
      next_st.rvalid = cfg_i.rd;
      next_st.rdata = 16'h0000;
      if (cfg_i.wr) begin
         unique case (cfg_i.addr)
            OFF_IO_BASE_LOW: begin
               next_st.base_nib = cfg_i.wdata[7:4];
               if (cfg_i.size16[1]) begin
                  next_st.limit_nib = cfg_i.wdata[15:12];
               end
            end
            OFF_IO_LIMIT_LOW: begin
               next_st.limit_nib = cfg_i.wdata[7:4];
            end
            OFF_IO_BASE_HIGH: begin
               next_st.base_high = cfg_i.wdata;
            end
            OFF_IO_LIMIT_HIGH: begin
               next_st.limit_high = cfg_i.wdata;
            end
            default: begin
               next_st.base_nib = st.base_nib;
            end
         endcase
      end
      if (cfg_i.rd) begin
         unique case (cfg_i.addr)
            OFF_IO_BASE_LOW: begin
               next_st.rdata = {st.limit_nib, IO_LOW_NIBBLE,
                                st.base_nib, IO_LOW_NIBBLE};
            end
            OFF_IO_LIMIT_LOW: begin
               next_st.rdata = {8'h00, st.limit_nib, IO_LOW_NIBBLE};
            end
            OFF_IO_BASE_HIGH: begin
               next_st.rdata = st.base_high;
            end
            OFF_IO_LIMIT_HIGH: begin
               next_st.rdata = st.limit_high;
            end
            default: begin
               next_st.rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st.base_nib <= RST_BASE_NIB;
         st.base_high <= RST_HIGH;
         st.limit_nib <= RST_LIMIT_NIB;
         st.limit_high <= RST_HIGH;
         st.rdata <= 16'h0000;
         st.rvalid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

endmodule // io_address_decoder

//--- tb/sec_initiator.sv
`timescale 1ns/1ps
module sec_initiator (
   input wire logic mclk_i,
   output logic sec_valid_o,
   output logic sec_is_io_o,
   output logic [31:0] sec_addr_o
);
   initial {sec_valid_o, sec_is_io_o, sec_addr_o} = '0;
   task issue(input logic io, input logic [31:0] a);
      @(posedge mclk_i);
      #1 {sec_valid_o, sec_is_io_o, sec_addr_o} = {1'b1, io, a};
   endtask
endmodule // sec_initiator

//--- tb/io_decoder_props.sv
`timescale 1ns/1ps
module io_decoder_props (
   input wire logic mclk_i, rstn_i, io_enable_i, master_enable_i,
   input wire logic isa_enable_i, pri_io_valid_i, sec_valid_i, sec_is_io_i,
   input wire logic pri_fwd_down_o, sec_fwd_up_o,
   input wire io_decode_pkg::cfg_req_t cfg_i,
   input wire logic [31:0] pri_io_addr_i, sec_addr_i, io_base_o, io_limit_o
);
   wire [31:0] pa = pri_io_addr_i;
   wire [31:0] sa = sec_addr_i;
   wire pin = pa >= io_base_o && pa <= io_limit_o;
   wire sin = sa >= io_base_o && sa <= io_limit_o;
   wire plo = isa_enable_i && pa[31:16] == 16'h0 && pa[9:8] != 2'h0;
   wire slo = isa_enable_i && sa[31:16] == 16'h0 && sa[9:8] != 2'h0;
   wire pv = pri_io_valid_i && io_enable_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   property p_io; !io_enable_i |-> !pri_fwd_down_o; endproperty
   a_io: assert property (p_io) else $error("io off claim");
   property p_ms; !master_enable_i |-> !sec_fwd_up_o; endproperty
   a_ms: assert property (p_ms) else $error("master off up");
   property p_win; pv && !isa_enable_i |-> pri_fwd_down_o == pin; endproperty
   a_win: assert property (p_win) else $error("window down");
   property p_hi; pv && pa[31:16] != 16'h0 |-> pri_fwd_down_o == pin; endproperty
   a_hi: assert property (p_hi) else $error("high decode");
   property p_hole; pri_io_valid_i && plo |-> !pri_fwd_down_o; endproperty
   a_hole: assert property (p_hole) else $error("isa claim");
   property p_up; sec_valid_i && sec_is_io_i && master_enable_i
      |-> sec_fwd_up_o == (!sin || slo); endproperty
   a_up: assert property (p_up) else $error("up decode");
   property p_fill; io_base_o[11:0] == 12'h0 && io_limit_o[11:0] == 12'hfff;
   endproperty
   a_fill: assert property (p_fill) else $error("fill bits");
   property p_bh; cfg_i.wr && cfg_i.addr == 8'h30
      |=> io_base_o[31:16] == $past(cfg_i.wdata); endproperty
   a_bh: assert property (p_bh) else $error("base high");
endmodule // io_decoder_props
bind io_address_decoder io_decoder_props u_props (.*);

//--- tb/tb_io_address_decoder.sv
`timescale 1ns/1ps
module tb_io_address_decoder;
   import io_decode_pkg::*;
   logic mclk_i, rstn_i, io_enable_i, master_enable_i, isa_enable_i;
   logic pri_io_valid_i, sec_valid_i, sec_is_io_i, cfg_rvalid_o;
   logic pri_fwd_down_o, sec_fwd_up_o;
   logic [15:0] cfg_rdata_o;
   logic [31:0] pri_io_addr_i, sec_addr_i, io_base_o, io_limit_o;
   cfg_req_t cfg_i;
   int fails = 0, num_checks = 0, cyc = 0;
   io_address_decoder u_dut (.*);
   sec_initiator u_part (.mclk_i, .sec_valid_o(sec_valid_i),
      .sec_is_io_o(sec_is_io_i), .sec_addr_o(sec_addr_i));
   task chk(input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task final_report;
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task cfg(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      #1 cfg_i = '{w, !w, a, 2'h2, d};
      @(posedge mclk_i);
      #1 cfg_i = '0;
      if (!w) chk(cfg_rvalid_o, 1);
      if (!w) chk(cfg_rdata_o, d);
   endtask
   task setup(input logic [15:0] bh, lh, lo);
      {io_enable_i, master_enable_i} = 2'h0;
      cfg(1, 8'h30, bh);
      cfg(1, 8'h32, lh);
      cfg(1, 8'h1c, lo);
      {io_enable_i, master_enable_i} = 2'h3;
   endtask
   task pd(input logic [31:0] a, input logic e);
      @(posedge mclk_i);
      #1 {pri_io_valid_i, pri_io_addr_i} = {1'b1, a};
      #1 chk(pri_fwd_down_o, e);
   endtask
   task su(input logic io, input logic [31:0] a, input logic e);
      u_part.issue(io, a);
      #1 chk(sec_fwd_up_o, e);
   endtask
   initial begin
      mclk_i = 0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) if (++cyc == 3000) begin
      fails++;
      final_report;
   end
   initial begin
      {rstn_i, io_enable_i, master_enable_i, isa_enable_i} = '0;
      {cfg_i, pri_io_valid_i, pri_io_addr_i} = '0;
      repeat (4) @(posedge mclk_i);
      #1 rstn_i = 1;
      cfg(0, 8'h1c, 16'h0101);
      cfg(0, 8'h40, 16'h0);
      chk(io_limit_o, 32'h0fff);
      setup(16'h0001, 16'h0002, 16'h8f4f);
      cfg(0, 8'h1d, 16'h0081);
      cfg(0, 8'h32, 16'h0002);
      pd(32'h0001_3fff, 0);
      pd(32'h0001_4000, 1);
      pd(32'h0002_8fff, 1);
      pd(32'h0002_9000, 0);
      su(1, 32'h0001_3fff, 1);
      su(1, 32'h0001_4000, 0);
      su(0, 32'h0001_4000, 1);
      io_enable_i = 0;
      pd(32'h0001_4000, 0);
      master_enable_i = 0;
      su(1, 32'h0, 0);
      isa_enable_i = 1;
      setup(16'h0, 16'h0001, 16'hf101);
      pd(32'h0400, 1);
      pd(32'h0500, 0);
      pd(32'h03ff, 0);
      pd(32'h0001_0500, 1);
      su(1, 32'h0700, 1);
      su(1, 32'h0400, 0);
      isa_enable_i = 0;
      setup(16'h0, 16'h0, 16'h1121);
      pd(32'h2000, 0);
      su(1, 32'h1fff, 1);
      final_report;
   end
endmodule // tb_io_address_decoder
